// file: verilog/ofc_flash_ctrl.v
// On-chip flash controller with its array, protection, pulse timer and
// completion/violation interrupt sources.
// Assumes all inputs come from logic on SYS_CLK; commands are one-cycle strobes.
//
// Behaviour
// (RQ1) Erase works on 1 kB blocks; every erased byte reads 0xFF.
// (RQ2) Each 2 kB region holds its own protection: read/write, read-only, execute-only.
// (RQ3) Erase or program of a read-only region is refused; reads still allowed.
// (RQ4) Execute-only regions allow only instruction fetches; data and debug reads refused; code serves them in the reload cycle after reset.
// (RQ5) Erase of a read-only or execute-only block fails and keeps contents.
// (RQ6) Program one 32-bit word; stored value is old AND new.
// (RQ7) Erase and program pulse lengths are timed here in microseconds of clock.
// (RQ8) Software sets cycles per microsecond before erase or program.
// (RQ9) Any disallowed access sets the access-violation source; code omits misaligned commands and refused protection changes.
// (RQ10) Each finished erase or program sets the completion source.
// (RQ11) Protection acts at once; a separate commit makes it permanent, irreversibly.
// (RQ12) Per-source enable mask; only enabled sources drive the interrupt output.
// (RQ13) Raw and masked status both readable; masked is raw AND enable.
// (RQ14) A source stays set until software clears it.
// (RQ15) Handler should clear the source early to avoid re-entry.
// (RQ16) Uncommitted protection is dropped at reset, restoring committed values.
// (RQ17) Protection may only tighten; execute-only regions refuse any change.
// (RQ18) Busy from accepted erase/program until done; no new request while busy.
// (RQ19) Misaligned or out-of-range erase or program is refused and flagged.
`timescale 1ns/1ps
`include "ofc_defs.vh"

module ofc_flash_ctrl #(
    parameter AW         = 13,
    parameter ERASE_US   = `OFC_ERASE_US,
    parameter PROG_US    = `OFC_PROG_US
) (
    input  wire          SYS_CLK,
    input  wire          RST_B,
    input  wire          CLK_EN,
    input  wire          USEC_WR,
    input  wire [7:0]    USEC_CLOCKS,
    output wire [7:0]    USEC_VALUE,
    input  wire          CMD_VALID,
    input  wire          CMD_ERASE,
    input  wire [AW-1:0] CMD_ADDR,
    input  wire [31:0]   CMD_WDATA,
    output wire          BUSY,
    output reg           OP_FAIL,
    input  wire          RD_VALID,
    input  wire          RD_FETCH,
    input  wire [AW-1:0] RD_ADDR,
    output reg  [31:0]   RD_DATA,
    output reg           RD_ACK,
    output reg           RD_DENIED,
    input  wire          PROT_SET,
    input  wire [AW-1:0] PROT_ADDR,
    input  wire [1:0]    PROT_MODE,
    input  wire          PROT_COMMIT,
    output reg           PROT_FAIL,
    output wire [1:0]    PROT_VALUE,
    input  wire          OP_DONE_INT_ENABLE_BIT,
    input  wire          ACCESS_VIOLATION_INT_ENABLE_BIT,
    input  wire          OP_DONE_INT_CLEAR_BIT,
    input  wire          ACCESS_VIOLATION_INT_CLEAR_BIT,
    input  wire          STATUS_VIEW_SELECT,
    output wire [1:0]    INT_STATUS,
    output wire          FLASH_IRQ
);

    // ****************************************************************
    // Sizes and states
    // ****************************************************************
    localparam WORDS   = 1 << (AW - `OFC_WORD_LSB);
    localparam REGIONS = 1 << (AW - `OFC_REGION_LSB);
    localparam BW      = `OFC_BLOCK_LSB - `OFC_WORD_LSB;
    localparam RW      = AW - `OFC_REGION_LSB;

    localparam [2:0] S_IDLE  = 3'h1;
    localparam [2:0] S_PULSE = 3'h2;
    localparam [2:0] S_WIPE  = 3'h4;

    // ****************************************************************
    // Reset release
    // ****************************************************************
    reg rst_meta_q;
    reg rst_n_q;
    always @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ****************************************************************
    // Array and protection storage
    // ****************************************************************
    reg [31:0] mem [0:WORDS-1];
    // Committed protection is non-volatile: no reset touches it
    reg [1:0]  prot_nv [0:REGIONS-1];
    reg [1:0]  prot_q  [0:REGIONS-1];
    reg        prot_load_q;
    integer    i;

    // Power-on image stands in for a blank part
    initial
    begin
        for (i = 0; i < WORDS; i = i + 1)
            mem[i] = `OFC_ERASED_WORD;
        for (i = 0; i < REGIONS; i = i + 1)
            prot_nv[i] = `OFC_PROT_RW;
    end

    wire [RW-1:0] set_rgn = PROT_ADDR[AW-1:`OFC_REGION_LSB];
    wire [1:0]    set_old = prot_q[set_rgn];
    // Tightening only; execute-only refuses everything, even a same-value write
    wire set_ok = (set_old != `OFC_PROT_XO)
                  && ((PROT_MODE == `OFC_PROT_XO)
                      || ((PROT_MODE == `OFC_PROT_RO) && (set_old == `OFC_PROT_RW))
                      || (PROT_MODE == set_old)); // RQ17

    genvar g;
    generate
        for (g = 0; g < REGIONS; g = g + 1)
        begin : g_prot
            // Working copy reloads from the committed copy after each reset
            always @(posedge SYS_CLK or negedge rst_n_q)
            begin
                if (!rst_n_q)
                    prot_q[g] <= `OFC_PROT_RW;
                else if (CLK_EN)
                begin
                    if (prot_load_q)
                        prot_q[g] <= prot_nv[g]; // RQ16
                    else if (PROT_SET && set_ok && (set_rgn == g))
                        prot_q[g] <= PROT_MODE; // RQ11 RQ2
                end
            end
            always @(posedge SYS_CLK)
            begin
                if (CLK_EN && !prot_load_q && PROT_COMMIT)
                    prot_nv[g] <= prot_q[g]; // RQ11
            end
        end
    endgenerate

    always @(posedge SYS_CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            prot_load_q <= 1'b1;
            PROT_FAIL   <= 1'b0;
        end
        else if (CLK_EN)
        begin
            prot_load_q <= 1'b0;
            if (PROT_SET && !prot_load_q)
                PROT_FAIL <= !set_ok; // RQ17
        end
    end

    assign PROT_VALUE = prot_q[set_rgn];

    // ****************************************************************
    // Command checks
    // ****************************************************************
    wire [1:0] cmd_prot  = prot_q[CMD_ADDR[AW-1:`OFC_REGION_LSB]];
    wire       cmd_align = CMD_ERASE ? (CMD_ADDR[`OFC_BLOCK_LSB-1:0] == {`OFC_BLOCK_LSB{1'b0}})
                                     : (CMD_ADDR[1:0] == 2'h0); // RQ19
    wire       cmd_prot_bad = (cmd_prot != `OFC_PROT_RW); // RQ3 RQ5
    reg  [2:0] state_q;
    wire       idle   = state_q[0];
    // Protection is not yet valid in the reload cycle, so commands wait for it
    wire       accept = CMD_VALID && idle && !prot_load_q && CLK_EN; // RQ18
    wire       go     = accept && cmd_align && !cmd_prot_bad;
    wire       rd_bad = (prot_q[RD_ADDR[AW-1:`OFC_REGION_LSB]] == `OFC_PROT_XO)
                        && !RD_FETCH; // RQ4

    assign BUSY = !idle; // RQ18

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    reg  [7:0]           usec_q;
    reg  [31:0]          cnt_q;
    reg  [AW-3:0]        waddr_q;
    reg  [31:0]          wdata_q;
    reg                  erase_q;
    reg                  done_raw_q;
    reg                  acc_raw_q;
    wire [31:0]          erase_cycles = ERASE_US * {24'h000000, usec_q};
    wire [31:0]          prog_cycles  = PROG_US * {24'h000000, usec_q};
    wire                 last_word    = (waddr_q[BW-1:0] == {BW{1'b1}});
    wire                 op_done      = (state_q[1] && !erase_q && (cnt_q <= 32'h1))
                                        || (state_q[2] && last_word); // RQ10

    always @(posedge SYS_CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= S_IDLE;
            usec_q  <= `OFC_USEC_RESET;
            cnt_q   <= 32'h00000000;
            waddr_q <= {(AW-2){1'b0}};
            wdata_q <= 32'h00000000;
            erase_q <= 1'b0;
            OP_FAIL <= 1'b0;
        end
        else if (CLK_EN)
        begin
            if (USEC_WR)
                usec_q <= USEC_CLOCKS; // RQ8
            if (accept)
                OP_FAIL <= !(cmd_align && !cmd_prot_bad); // RQ19 RQ5
            case (state_q)
                S_IDLE:
                begin
                    if (go)
                    begin
                        state_q <= S_PULSE;
                        erase_q <= CMD_ERASE;
                        waddr_q <= CMD_ADDR[AW-1:2];
                        wdata_q <= CMD_WDATA;
                        cnt_q   <= CMD_ERASE ? erase_cycles : prog_cycles; // RQ7
                    end
                end
                S_PULSE:
                begin
                    // A zero setting still gives a one-cycle pulse
                    if (cnt_q <= 32'h1)
                        state_q <= erase_q ? S_WIPE : S_IDLE;
                    else
                        cnt_q <= cnt_q - 32'h1; // RQ7
                end
                S_WIPE:
                begin
                    // One word per cycle after the pulse, to keep one write port
                    waddr_q <= waddr_q + {{(AW-3){1'b0}}, 1'b1};
                    if (last_word)
                        state_q <= S_IDLE;
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end

    assign USEC_VALUE = usec_q;

    always @(posedge SYS_CLK)
    begin
        if (CLK_EN && state_q[1] && !erase_q && (cnt_q <= 32'h1))
            mem[waddr_q] <= mem[waddr_q] & wdata_q; // RQ6
        else if (CLK_EN && state_q[2])
            mem[waddr_q] <= `OFC_ERASED_WORD; // RQ1
    end

    // ****************************************************************
    // Reads
    // ****************************************************************
    always @(posedge SYS_CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            RD_DATA   <= 32'h00000000;
            RD_ACK    <= 1'b0;
            RD_DENIED <= 1'b0;
        end
        else if (CLK_EN)
        begin
            RD_ACK    <= RD_VALID;
            RD_DENIED <= RD_VALID && rd_bad; // RQ4
            if (RD_VALID)
                RD_DATA <= rd_bad ? 32'h00000000 : mem[RD_ADDR[AW-1:2]];
        end
    end

    // ****************************************************************
    // Interrupt sources
    // ****************************************************************
    wire acc_set = (accept && cmd_prot_bad) || (RD_VALID && rd_bad && CLK_EN); // RQ9

    always @(posedge SYS_CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            done_raw_q <= 1'b0;
            acc_raw_q  <= 1'b0;
        end
        else if (CLK_EN)
        begin
            // New events win over a clear in the same cycle
            done_raw_q <= (done_raw_q && !OP_DONE_INT_CLEAR_BIT) || op_done; // RQ14 RQ10
            acc_raw_q  <= (acc_raw_q && !ACCESS_VIOLATION_INT_CLEAR_BIT) || acc_set; // RQ14
        end
    end

    wire [1:0] raw_st = {acc_raw_q, done_raw_q};
    wire [1:0] mask   = {ACCESS_VIOLATION_INT_ENABLE_BIT, OP_DONE_INT_ENABLE_BIT};
    assign INT_STATUS = STATUS_VIEW_SELECT ? (raw_st & mask) : raw_st; // RQ13
    assign FLASH_IRQ  = |(raw_st & mask); // RQ12

endmodule // ofc_flash_ctrl

// file: verilog/ofc_defs.vh
// Constants for the on-chip flash controller: geometry, protection codes,
// pulse times. Included by the controller; holds definitions only.
`ifndef OFC_DEFS_VH
`define OFC_DEFS_VH

// Geometry, as byte-address bit positions, and the erased word value
`define OFC_BLOCK_LSB     10
`define OFC_REGION_LSB    11
`define OFC_WORD_LSB      2
`define OFC_ERASED_WORD   32'hFFFFFFFF

// Protection codes
`define OFC_PROT_RW       2'h0
`define OFC_PROT_RO       2'h1
`define OFC_PROT_XO       2'h2

// Pulse times in microseconds
`define OFC_ERASE_US      32'h00002EE0
`define OFC_PROG_US       32'h00000014

// Reset value of the cycles-per-microsecond setting
`define OFC_USEC_RESET    8'h0A

`endif

// file: testbench/ofc_props.sv
// Checker for the flash controller, watching the top module's ports only.
// Assumes one clock domain and the bind below.
`timescale 1ns/1ps
// ****************
// Properties
// ****************
module ofc_props (
    input wire        SYS_CLK,
    input wire        RST_B,
    input wire        CLK_EN,
    input wire        CMD_VALID,
    input wire        RD_VALID,
    input wire        RD_FETCH,
    input wire        RD_ACK,
    input wire        RD_DENIED,
    input wire [31:0] RD_DATA,
    input wire        BUSY,
    input wire        OP_FAIL,
    input wire        OP_DONE_INT_ENABLE_BIT,
    input wire        ACCESS_VIOLATION_INT_ENABLE_BIT,
    input wire        OP_DONE_INT_CLEAR_BIT,
    input wire        ACCESS_VIOLATION_INT_CLEAR_BIT,
    input wire        STATUS_VIEW_SELECT,
    input wire [1:0]  INT_STATUS,
    input wire        FLASH_IRQ
);
    wire raw_v = !STATUS_VIEW_SELECT;
    wire done_en = OP_DONE_INT_ENABLE_BIT;
    wire av_en = ACCESS_VIOLATION_INT_ENABLE_BIT;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    property p_irq; raw_v |-> FLASH_IRQ == (INT_STATUS[0] && done_en || INT_STATUS[1] && av_en);
    endproperty
    a_irq: assert property (p_irq) else $error("irq differs from enabled flags");
    property p_masked; !raw_v |-> FLASH_IRQ == |INT_STATUS
        && !(INT_STATUS[0] && !done_en) && !(INT_STATUS[1] && !av_en); endproperty
    a_masked: assert property (p_masked) else $error("masked view wrong");
    property p_rd_ack; RD_VALID && CLK_EN |=> RD_ACK; endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("read not answered");
    property p_deny; RD_DENIED |-> RD_ACK && RD_DATA == 32'h0 && !$past(RD_FETCH); endproperty
    a_deny: assert property (p_deny) else $error("bad denied read");
    property p_deny_flag; RD_DENIED && raw_v |-> ##[0:1] INT_STATUS[1]; endproperty
    a_deny_flag: assert property (p_deny_flag) else $error("no violation flag");
    property p_done; $fell(BUSY) && raw_v |-> INT_STATUS[0]; endproperty
    a_done: assert property (p_done) else $error("no completion flag");
    property p_busy; $rose(BUSY) |-> BUSY[*2] ##[1:400] !BUSY; endproperty
    a_busy: assert property (p_busy) else $error("busy length wrong");
    property p_refuse; BUSY && CMD_VALID |=> $stable(OP_FAIL); endproperty
    a_refuse: assert property (p_refuse) else $error("request taken while busy");
    property p_clr; OP_DONE_INT_CLEAR_BIT && CLK_EN && !BUSY && raw_v ##1 raw_v
        |-> !INT_STATUS[0]; endproperty
    a_clr: assert property (p_clr) else $error("clear ignored");
    property p_hold; raw_v && INT_STATUS[1] && !ACCESS_VIOLATION_INT_CLEAR_BIT ##1 raw_v
        |-> INT_STATUS[1]; endproperty
    a_hold: assert property (p_hold) else $error("flag dropped");
    c_deny: cover property (RD_DENIED);
    c_done: cover property ($fell(BUSY));
    c_irq: cover property (FLASH_IRQ && STATUS_VIEW_SELECT);
endmodule // ofc_props
bind ofc_flash_ctrl ofc_props u_ofc_props (
    .SYS_CLK                         (SYS_CLK),
    .RST_B                           (RST_B),
    .CLK_EN                          (CLK_EN),
    .CMD_VALID                       (CMD_VALID),
    .RD_VALID                        (RD_VALID),
    .RD_FETCH                        (RD_FETCH),
    .RD_ACK                          (RD_ACK),
    .RD_DENIED                       (RD_DENIED),
    .RD_DATA                         (RD_DATA),
    .BUSY                            (BUSY),
    .OP_FAIL                         (OP_FAIL),
    .OP_DONE_INT_ENABLE_BIT          (OP_DONE_INT_ENABLE_BIT),
    .ACCESS_VIOLATION_INT_ENABLE_BIT (ACCESS_VIOLATION_INT_ENABLE_BIT),
    .OP_DONE_INT_CLEAR_BIT           (OP_DONE_INT_CLEAR_BIT),
    .ACCESS_VIOLATION_INT_CLEAR_BIT  (ACCESS_VIOLATION_INT_CLEAR_BIT),
    .STATUS_VIEW_SELECT              (STATUS_VIEW_SELECT),
    .INT_STATUS                      (INT_STATUS),
    .FLASH_IRQ                       (FLASH_IRQ)
);

// file: testbench/ofc_host_model.sv
// Software side model: sets cycles per microsecond after every reset release.
// Assumes the first command follows its write.
`timescale 1ns/1ps
// ****************
// Host model
// ****************
module ofc_host_model (
    input  wire       clk,
    input  wire       rst_b,
    output reg        usec_wr,
    output reg  [7:0] usec_clocks
);
    initial
    begin
        usec_wr = 1'b0;
        usec_clocks = 8'h01;
        // Reset puts the setting back to its default, so software repeats it
        forever
        begin
            @(posedge rst_b);
            repeat (3) @(posedge clk);
            #10 usec_wr = 1'b1;
            @(posedge clk);
            #10 usec_wr = 1'b0;
        end
    end
endmodule // ofc_host_model

// file: testbench/onchip_flash_controller_tb.sv
// Self-checking bench for the flash controller with short pulse parameters.
// Assumes the host model sets one cycle per microsecond.
`timescale 1ns/1ps
// ****************
// Bench
// ****************
module onchip_flash_controller_tb;
    reg         SYS_CLK = 1'b0, RST_B = 1'b0, CLK_EN = 1'b1, STATUS_VIEW_SELECT = 1'b0;
    reg         CMD_VALID = 1'b0, CMD_ERASE = 1'b0, RD_VALID = 1'b0, RD_FETCH = 1'b0;
    reg         PROT_SET = 1'b0, PROT_COMMIT = 1'b0;
    reg         OP_DONE_INT_ENABLE_BIT = 1'b0, ACCESS_VIOLATION_INT_ENABLE_BIT = 1'b0;
    reg         OP_DONE_INT_CLEAR_BIT = 1'b0, ACCESS_VIOLATION_INT_CLEAR_BIT = 1'b0;
    reg  [12:0] CMD_ADDR = 13'h0, RD_ADDR = 13'h0, PROT_ADDR = 13'h0;
    reg  [31:0] CMD_WDATA = 32'h0;
    reg  [1:0]  PROT_MODE = 2'h0;
    wire        USEC_WR, BUSY, OP_FAIL, RD_ACK, RD_DENIED, PROT_FAIL, FLASH_IRQ;
    wire [7:0]  USEC_CLOCKS, USEC_VALUE;
    wire [31:0] RD_DATA;
    wire [1:0]  PROT_VALUE, INT_STATUS;
    integer     n_errors = 0, n_tests = 0, i;
    ofc_flash_ctrl #(.AW(13), .ERASE_US(4), .PROG_US(2)) u_ofc_flash_ctrl (
        .SYS_CLK                         (SYS_CLK),
        .RST_B                           (RST_B),
        .CLK_EN                          (CLK_EN),
        .USEC_WR                         (USEC_WR),
        .USEC_CLOCKS                     (USEC_CLOCKS),
        .USEC_VALUE                      (USEC_VALUE),
        .CMD_VALID                       (CMD_VALID),
        .CMD_ERASE                       (CMD_ERASE),
        .CMD_ADDR                        (CMD_ADDR),
        .CMD_WDATA                       (CMD_WDATA),
        .BUSY                            (BUSY),
        .OP_FAIL                         (OP_FAIL),
        .RD_VALID                        (RD_VALID),
        .RD_FETCH                        (RD_FETCH),
        .RD_ADDR                         (RD_ADDR),
        .RD_DATA                         (RD_DATA),
        .RD_ACK                          (RD_ACK),
        .RD_DENIED                       (RD_DENIED),
        .PROT_SET                        (PROT_SET),
        .PROT_ADDR                       (PROT_ADDR),
        .PROT_MODE                       (PROT_MODE),
        .PROT_COMMIT                     (PROT_COMMIT),
        .PROT_FAIL                       (PROT_FAIL),
        .PROT_VALUE                      (PROT_VALUE),
        .OP_DONE_INT_ENABLE_BIT          (OP_DONE_INT_ENABLE_BIT),
        .ACCESS_VIOLATION_INT_ENABLE_BIT (ACCESS_VIOLATION_INT_ENABLE_BIT),
        .OP_DONE_INT_CLEAR_BIT           (OP_DONE_INT_CLEAR_BIT),
        .ACCESS_VIOLATION_INT_CLEAR_BIT  (ACCESS_VIOLATION_INT_CLEAR_BIT),
        .STATUS_VIEW_SELECT              (STATUS_VIEW_SELECT),
        .INT_STATUS                      (INT_STATUS),
        .FLASH_IRQ                       (FLASH_IRQ)
    );
    ofc_host_model u_ofc_host_model (.clk(SYS_CLK), .rst_b(RST_B), .usec_wr(USEC_WR),
        .usec_clocks(USEC_CLOCKS));
    always #50 SYS_CLK = ~SYS_CLK;
    task tick(input integer n);
    begin
        repeat (n) @(posedge SYS_CLK);
        #10;
    end
    endtask
    task report_and_stop;
    begin
        $display("errors %0d checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task idle_wait;
    begin
        for (i = 0; BUSY !== 1'b0 && i < 600; i = i + 1)
            tick(1);
        if (BUSY !== 1'b0)
        begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t: busy timeout", $time);
            report_and_stop;
        end
    end
    endtask
    task cmd(input er, input [12:0] a, input [31:0] d, input f);
    begin
        CMD_ERASE = er;
        CMD_ADDR = a;
        CMD_WDATA = d;
        CMD_VALID = 1'b1;
        tick(1);
        CMD_VALID = 1'b0;
        chk(OP_FAIL, f);
        chk(BUSY, !f);
        idle_wait;
        tick(1);
    end
    endtask
    task rd(input ft, input [12:0] a, input [31:0] d, input dn);
    begin
        RD_FETCH = ft;
        RD_ADDR = a;
        RD_VALID = 1'b1;
        tick(1);
        RD_VALID = 1'b0;
        chk(RD_DATA, d);
        chk(RD_DENIED, dn);
        chk(RD_ACK, 1'b1);
        tick(1);
        chk(RD_ACK, 1'b0);
    end
    endtask
    task prot(input [12:0] a, input [1:0] m, input f, input [1:0] v);
    begin
        PROT_ADDR = a;
        PROT_MODE = m;
        PROT_SET = 1'b1;
        tick(1);
        PROT_SET = 1'b0;
        chk(PROT_FAIL, f);
        chk(PROT_VALUE, v);
        tick(1);
    end
    endtask
    // Clear both sources straight after looking, as a handler should
    task flags(input [1:0] e);
    begin
        chk(INT_STATUS, e);
        OP_DONE_INT_CLEAR_BIT = 1'b1;
        ACCESS_VIOLATION_INT_CLEAR_BIT = 1'b1;
        tick(1);
        OP_DONE_INT_CLEAR_BIT = 1'b0;
        ACCESS_VIOLATION_INT_CLEAR_BIT = 1'b0;
        chk(INT_STATUS, 2'h0);
    end
    endtask
    initial
    begin
        tick(4);
        RST_B = 1'b1;
        chk(USEC_VALUE, 8'h0A);
        tick(6);
        chk(USEC_VALUE, 8'h01);
        cmd(1'b0, 13'h03FC, 32'h0, 1'b0);
        STATUS_VIEW_SELECT = 1'b1;
        tick(1);
        chk({FLASH_IRQ, INT_STATUS}, 3'h0);
        OP_DONE_INT_ENABLE_BIT = 1'b1;
        tick(1);
        chk({FLASH_IRQ, INT_STATUS}, 3'h5);
        STATUS_VIEW_SELECT = 1'b0;
        tick(1);
        flags(2'h1);
        cmd(1'b0, 13'h0404, 32'hA5A5F00F, 1'b0);
        cmd(1'b0, 13'h0404, 32'h0F0FFFFF, 1'b0);
        rd(1'b0, 13'h0404, 32'h0505F00F, 1'b0);
        CMD_ERASE = 1'b1;
        CMD_ADDR = 13'h0400;
        CMD_VALID = 1'b1;
        tick(1);
        CMD_ERASE = 1'b0;
        CMD_ADDR = 13'h07F8;
        tick(1);
        CMD_VALID = 1'b0;
        idle_wait;
        flags(2'h1);
        rd(1'b0, 13'h0404, 32'hFFFFFFFF, 1'b0);
        rd(1'b0, 13'h03FC, 32'h0, 1'b0);
        rd(1'b0, 13'h07F8, 32'hFFFFFFFF, 1'b0);
        cmd(1'b1, 13'h0200, 32'h0, 1'b1);
        cmd(1'b0, 13'h0406, 32'h0, 1'b1);
        flags(2'h0);
        ACCESS_VIOLATION_INT_ENABLE_BIT = 1'b1;
        prot(13'h1000, 2'h0, 1'b0, 2'h0);
        prot(13'h0800, 2'h1, 1'b0, 2'h1);
        cmd(1'b0, 13'h0800, 32'h0, 1'b1);
        cmd(1'b1, 13'h0C00, 32'h0, 1'b1);
        flags(2'h2);
        rd(1'b0, 13'h0800, 32'hFFFFFFFF, 1'b0);
        prot(13'h0800, 2'h0, 1'b1, 2'h1);
        prot(13'h0800, 2'h2, 1'b0, 2'h2);
        rd(1'b0, 13'h0800, 32'h0, 1'b1);
        rd(1'b1, 13'h0800, 32'hFFFFFFFF, 1'b0);
        cmd(1'b1, 13'h0800, 32'h0, 1'b1);
        flags(2'h2);
        // Frozen clock enable: the request must leave no trace
        CLK_EN = 1'b0;
        cmd(1'b0, 13'h1008, 32'h0, 1'b1);
        CLK_EN = 1'b1;
        rd(1'b0, 13'h1008, 32'hFFFFFFFF, 1'b0);
        prot(13'h0800, 2'h1, 1'b1, 2'h2);
        PROT_COMMIT = 1'b1;
        tick(1);
        PROT_COMMIT = 1'b0;
        prot(13'h1000, 2'h1, 1'b0, 2'h1);
        RST_B = 1'b0;
        tick(2);
        chk(USEC_VALUE, 8'h0A);
        RST_B = 1'b1;
        tick(4);
        chk(PROT_VALUE, 2'h0);
        PROT_ADDR = 13'h0800;
        tick(1);
        chk(PROT_VALUE, 2'h2);
        cmd(1'b0, 13'h1004, 32'h0, 1'b0);
        rd(1'b0, 13'h1004, 32'h0, 1'b0);
        report_and_stop;
    end
endmodule // onchip_flash_controller_tb
